// ### design/sofl_pkg.sv
// package for the status output flag block: map, codes, types
package sofl_pkg;

  // ***********************************************************
  // register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] SOFL_OFF_CTRL = 8'h00;
  localparam logic [7:0] SOFL_OFF_SEL = 8'h04;
  localparam logic [7:0] SOFL_OFF_SPDERR = 8'h08;
  localparam logic [7:0] SOFL_OFF_LOSSTH = 8'h0c;
  localparam logic [7:0] SOFL_OFF_PVLIM = 8'h10;
  localparam logic [7:0] SOFL_OFF_TIMEOUT = 8'h14;
  localparam logic [7:0] SOFL_OFF_FLAGS = 8'h18;
  localparam logic [7:0] SOFL_OFF_ISTAT = 8'h1c;
  localparam logic [7:0] SOFL_OFF_IMASK = 8'h20;
  localparam logic [7:0] SOFL_OFF_ANALOG = 8'h24;

  // ***********************************************************
  // option codes for the relay output terminal
  // ***********************************************************
  localparam logic [7:0] SOFL_OPT_ZS = 8'h15;      // 21
  localparam logic [7:0] SOFL_OPT_SPDERR = 8'h16;  // 22
  localparam logic [7:0] SOFL_OPT_POSDN = 8'h17;   // 23
  localparam logic [7:0] SOFL_OPT_VLOSS = 8'h1b;   // 27
  localparam logic [7:0] SOFL_OPT_CLOSS = 8'h1c;   // 28
  localparam logic [7:0] SOFL_OPT_ALOSS = 8'h1d;   // 29
  localparam logic [7:0] SOFL_OPT_BOOST = 8'h1f;   // 31
  localparam logic [7:0] SOFL_OPT_SILENT = 8'h20;  // 32

  // ***********************************************************
  // field positions, reset values, timing
  // ***********************************************************
  localparam logic [7:0] SOFL_LOSS_OFF = 8'hff;    // 255 disables
  localparam logic [7:0] SOFL_PCT_MAX = 8'h64;     // 100 percent
  localparam int SOFL_CTRL_RTU_BIT = 0;
  localparam int SOFL_CTRL_ACT_LSB = 4;
  localparam logic [15:0] SOFL_ZS_HOLD_RST = 16'h0064;
  localparam logic [7:0] SOFL_SEL_RST = 8'h00;
  localparam logic [7:0] SOFL_TH_RST = SOFL_LOSS_OFF;
  localparam logic [15:0] SOFL_TMO_RST = 16'h0000; // 0 = silence off
  localparam int SOFL_TICK_NS = 1000000;           // 1 ms timer tick
  localparam int SOFL_CLK_NS = 10;
  localparam int SOFL_TICK_CYC = SOFL_TICK_NS / SOFL_CLK_NS;
  localparam int SOFL_NEV = 7;                     // event count

  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic zero_speed_flag;
    logic speed_error_flag;
    logic position_done_flag;
    logic voltage_loss_flag;
    logic current_input_loss_flag;
    logic aux_input_loss_flag;
    logic second_stage_boost;
    logic link_silence_flag;
  } sofl_flags_t;

  typedef struct packed {
    logic [7:0] voltage;
    logic [7:0] current;
    logic [7:0] aux;
  } sofl_analog_t;

endpackage : sofl_pkg

// ### design/sofl_top.sv
// status output flag logic with apb register file
// How it works
// - encoder flags stay low unless the encoder card is fitted
// - code 21: zero speed once encoder pulses have stopped
// - code 22: speed error while velocity error exceeds threshold
// - code 23: position done while position equals target
// - code 27: voltage loss below threshold; 255 disables compare
// - code 28: current input loss below its own threshold
// - code 29: aux input loss below its own threshold
// - threshold replaces measured value while input is below it
// - any input loss requests decel to stop, routed or not
// - code 31: boost on while running and pv below low limit
// - boost off once pv rises above high limit
// - between limits after release, boost stays off
// - run removed: boost off regardless of pv
// - code 32: only rtu traffic feeds the silence flag
// - silence flag when master quiet longer than timeout
// - silence flag held until valid rtu traffic resumes
// - timeout response comes from a separate action setting
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sofl_top
  import sofl_pkg::*;
#(
  parameter int TICK_CYC = SOFL_TICK_CYC,
  parameter int ZS_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_fitted,
  input wire logic encoder_pulse,
  input wire logic [15:0] velocity_error,
  input wire logic [15:0] load_position,
  input wire logic [15:0] target_position,
  input wire sofl_analog_t analog_in,
  input wire logic [7:0] process_variable,
  input wire logic forward_run_command,
  input wire logic rtu_frame_ok,
  input wire logic ascii_frame_ok,
  output logic relay_output_terminal,
  output sofl_flags_t flags,
  output sofl_analog_t analog_used,
  output logic decel_stop_req,
  output logic timeout_event,
  output logic [1:0] timeout_action_select,
  output logic irq
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [1:0] enc_sync;
    logic [1:0] run_sync;
    logic [1:0] card_sync;
    logic enc_last;
    logic [ZS_W-1:0] zs_cnt;
    logic [15:0] zs_hold;
    logic [7:0] sel;
    logic [15:0] spd_th;
    sofl_analog_t loss_th;
    logic [7:0] pv_high;
    logic [7:0] pv_low;
    logic [15:0] tmo;
    logic [1:0] act;
    logic rtu_only;
    logic [31:0] tick_cnt;
    logic [15:0] silent_ticks;
    sofl_flags_t fl;
    sofl_analog_t used;
    logic [SOFL_NEV-1:0] istat;
    logic [SOFL_NEV-1:0] imask;
    logic [31:0] rdata;
    logic tmo_pulse;
    logic relay;
  } sofl_state_t;

  sofl_state_t state_reg;
  sofl_state_t state_next;

  logic wr_hit;
  logic rd_hit;
  logic rd_setup;
  logic addr_ok;
  logic [SOFL_NEV-1:0] ev_now;
  logic [SOFL_NEV-1:0] ev_prev;
  logic run_now;
  logic card_now;
  logic enc_edge;
  logic frame_seen;

  // single-cycle access: answer in the access phase
  assign pready = 1'b1;
  assign wr_hit = psel && penable && pwrite;
  assign rd_hit = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite; // read word loads here
  always_comb begin
    case (paddr)
      SOFL_OFF_CTRL, SOFL_OFF_SEL, SOFL_OFF_SPDERR, SOFL_OFF_LOSSTH,
      SOFL_OFF_PVLIM, SOFL_OFF_TIMEOUT, SOFL_OFF_FLAGS, SOFL_OFF_ISTAT,
      SOFL_OFF_IMASK, SOFL_OFF_ANALOG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  assign run_now = state_reg.run_sync[1];
  assign card_now = state_reg.card_sync[1];
  assign enc_edge = state_reg.enc_sync[1] != state_reg.enc_last;
  // ascii frames never restart the timer, whatever rtu_only holds;
  // that bit stays a plain read-back flag for software
  assign frame_seen = rtu_frame_ok;

  // rising edges of every flag but position done feed the sticky status bits
  assign ev_prev = {state_reg.fl.zero_speed_flag,
    state_reg.fl.speed_error_flag, state_reg.fl.voltage_loss_flag,
    state_reg.fl.current_input_loss_flag,
    state_reg.fl.aux_input_loss_flag, state_reg.fl.second_stage_boost,
    state_reg.fl.link_silence_flag};

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    logic [7:0] ain [3];
    logic [7:0] ath [3];
    logic [2:0] lost;
    logic silent_now;
    state_next = state_reg;
    ain[0] = analog_in.voltage;
    ain[1] = analog_in.current;
    ain[2] = analog_in.aux;
    ath[0] = state_reg.loss_th.voltage;
    ath[1] = state_reg.loss_th.current;
    ath[2] = state_reg.loss_th.aux;
    lost = 3'b000;
    silent_now = 1'b0;
    // pin synchronisers
    state_next.enc_sync = {state_reg.enc_sync[0], encoder_pulse};
    state_next.run_sync = {state_reg.run_sync[0], forward_run_command};
    state_next.card_sync = {state_reg.card_sync[0], card_fitted};
    state_next.enc_last = state_reg.enc_sync[1];
    // zero speed: no encoder edge for zs_hold cycles
    if (enc_edge) begin
      state_next.zs_cnt = '0;
    end else if (state_reg.zs_cnt != {ZS_W{1'b1}}) begin
      state_next.zs_cnt = state_reg.zs_cnt + 1'b1;
    end
    state_next.fl.zero_speed_flag = card_now &&
      (state_reg.zs_cnt >= ZS_W'(state_reg.zs_hold));
    state_next.fl.speed_error_flag = card_now &&
      (velocity_error > state_reg.spd_th);
    state_next.fl.position_done_flag = card_now &&
      (load_position == target_position);
    // analog loss: 255 switches the compare off
    for (int i = 0; i < 3; i++) begin
      lost[i] = (ath[i] != SOFL_LOSS_OFF) && (ain[i] < ath[i]);
    end
    state_next.fl.voltage_loss_flag = lost[0];
    state_next.fl.current_input_loss_flag = lost[1];
    state_next.fl.aux_input_loss_flag = lost[2];
    state_next.used.voltage = lost[0] ? ath[0] : ain[0];
    state_next.used.current = lost[1] ? ath[1] : ain[1];
    state_next.used.aux = lost[2] ? ath[2] : ain[2];
    // boost hysteresis; stop clears it whatever the pv does
    if (!run_now) begin
      state_next.fl.second_stage_boost = 1'b0;
    end else if (process_variable < state_reg.pv_low) begin
      state_next.fl.second_stage_boost = 1'b1;
    end else if (process_variable > state_reg.pv_high) begin
      state_next.fl.second_stage_boost = 1'b0;
    end // between limits the flag keeps its value
    // silence timer in whole ticks; timeout 0 disables
    state_next.tmo_pulse = 1'b0;
    if (frame_seen) begin
      state_next.tick_cnt = '0;
      state_next.silent_ticks = '0;
      state_next.fl.link_silence_flag = 1'b0;
    end else begin
      if (state_reg.tick_cnt >= 32'(TICK_CYC - 1)) begin
        state_next.tick_cnt = '0;
        if (state_reg.silent_ticks != 16'hffff) begin
          state_next.silent_ticks = state_reg.silent_ticks + 16'h0001;
        end
      end else begin
        state_next.tick_cnt = state_reg.tick_cnt + 32'h00000001;
      end
      silent_now = (state_reg.tmo != '0) &&
        (state_reg.silent_ticks > state_reg.tmo);
      if (silent_now && !state_reg.fl.link_silence_flag) begin
        state_next.fl.link_silence_flag = 1'b1;
        state_next.tmo_pulse = 1'b1;
      end
    end
    // relay output multiplexer
    case (state_reg.sel)
      SOFL_OPT_ZS: state_next.relay = state_reg.fl.zero_speed_flag;
      SOFL_OPT_SPDERR: state_next.relay = state_reg.fl.speed_error_flag;
      SOFL_OPT_POSDN: state_next.relay = state_reg.fl.position_done_flag;
      SOFL_OPT_VLOSS: state_next.relay = state_reg.fl.voltage_loss_flag;
      SOFL_OPT_CLOSS:
        state_next.relay = state_reg.fl.current_input_loss_flag;
      SOFL_OPT_ALOSS: state_next.relay = state_reg.fl.aux_input_loss_flag;
      SOFL_OPT_BOOST: state_next.relay = state_reg.fl.second_stage_boost;
      SOFL_OPT_SILENT: state_next.relay = state_reg.fl.link_silence_flag;
      default: state_next.relay = 1'b0;
    endcase
    // register writes
    if (wr_hit) begin
      case (paddr)
        SOFL_OFF_CTRL: begin
          state_next.rtu_only = pwdata[SOFL_CTRL_RTU_BIT];
          state_next.act = pwdata[SOFL_CTRL_ACT_LSB +: 2];
        end
        SOFL_OFF_SEL: state_next.sel = pwdata[7:0];
        SOFL_OFF_SPDERR: begin
          state_next.spd_th = pwdata[15:0];
          state_next.zs_hold = pwdata[31:16];
        end
        SOFL_OFF_LOSSTH: state_next.loss_th = pwdata[23:0];
        SOFL_OFF_PVLIM: begin
          state_next.pv_high = pwdata[15:8];
          state_next.pv_low = pwdata[7:0];
        end
        SOFL_OFF_TIMEOUT: state_next.tmo = pwdata[15:0];
        SOFL_OFF_IMASK: state_next.imask = pwdata[SOFL_NEV-1:0];
        default: state_next.sel = state_reg.sel;
      endcase
    end
    // read word loaded in the setup cycle so prdata comes from a flop
    state_next.rdata = '0;
    if (rd_setup) begin
      case (paddr)
        SOFL_OFF_CTRL: state_next.rdata = {26'h0, state_reg.act,
          3'h0, state_reg.rtu_only};
        SOFL_OFF_SEL: state_next.rdata = {24'h0, state_reg.sel};
        SOFL_OFF_SPDERR: state_next.rdata = {state_reg.zs_hold,
          state_reg.spd_th};
        SOFL_OFF_LOSSTH: state_next.rdata = {8'h0, state_reg.loss_th};
        SOFL_OFF_PVLIM: state_next.rdata = {16'h0, state_reg.pv_high,
          state_reg.pv_low};
        SOFL_OFF_TIMEOUT: state_next.rdata = {16'h0, state_reg.tmo};
        SOFL_OFF_FLAGS: state_next.rdata = {24'h0, state_reg.fl};
        SOFL_OFF_ISTAT: state_next.rdata = {25'h0, state_reg.istat};
        SOFL_OFF_IMASK: state_next.rdata = {25'h0, state_reg.imask};
        SOFL_OFF_ANALOG: state_next.rdata = {8'h0, state_reg.used};
        default: state_next.rdata = '0;
      endcase
    end
    // status read clears only what was reported; a new event still wins
    ev_now = {state_next.fl.zero_speed_flag,
      state_next.fl.speed_error_flag, state_next.fl.voltage_loss_flag,
      state_next.fl.current_input_loss_flag,
      state_next.fl.aux_input_loss_flag, state_next.fl.second_stage_boost,
      state_next.fl.link_silence_flag};
    if (rd_hit && paddr == SOFL_OFF_ISTAT) begin
      state_next.istat = (state_reg.istat &
        ~state_reg.rdata[SOFL_NEV-1:0]) | (ev_now & ~ev_prev);
    end else begin
      state_next.istat = state_reg.istat | (ev_now & ~ev_prev);
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.sel <= SOFL_SEL_RST;
      state_reg.loss_th <= {SOFL_TH_RST, SOFL_TH_RST, SOFL_TH_RST};
      state_reg.zs_hold <= SOFL_ZS_HOLD_RST;
      state_reg.tmo <= SOFL_TMO_RST;
      state_reg.pv_high <= SOFL_PCT_MAX;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs; read word stands for the whole access cycle
  assign prdata = state_reg.rdata;
  assign relay_output_terminal = state_reg.relay;
  assign flags = state_reg.fl;
  assign analog_used = state_reg.used;
  assign decel_stop_req = state_reg.fl.voltage_loss_flag ||
    state_reg.fl.current_input_loss_flag ||
    state_reg.fl.aux_input_loss_flag;
  assign timeout_event = state_reg.tmo_pulse;
  assign timeout_action_select = state_reg.act;
  assign irq = |(state_reg.istat & state_reg.imask);

  // ***********************************************************
  // assertions
  // ***********************************************************
  a_boost_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    !run_now |=> !flags.second_stage_boost)
    else $error("boost on while stopped");
  a_boost_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && process_variable < state_reg.pv_low
    |=> flags.second_stage_boost)
    else $error("boost missing below low limit");
  a_boost_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && process_variable > state_reg.pv_high &&
    process_variable >= state_reg.pv_low
    |=> !flags.second_stage_boost)
    else $error("boost held above high limit");
  a_boost_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && process_variable >= state_reg.pv_low &&
    process_variable <= state_reg.pv_high
    |=> $stable(flags.second_stage_boost))
    else $error("boost changed between limits");
  a_enc_card: assert property (
    @(posedge pclk) disable iff (!presetn)
    !card_now |=> !flags.zero_speed_flag && !flags.speed_error_flag &&
    !flags.position_done_flag)
    else $error("encoder flag without card");
  a_speed_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    card_now && velocity_error > state_reg.spd_th
    |=> flags.speed_error_flag)
    else $error("speed error flag missing");
  a_pos_done: assert property (
    @(posedge pclk) disable iff (!presetn)
    card_now && load_position == target_position
    |=> flags.position_done_flag)
    else $error("position done flag missing");
  a_loss_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg.loss_th.voltage == SOFL_LOSS_OFF
    |=> !flags.voltage_loss_flag)
    else $error("loss flag with compare disabled");
  a_aux_loss: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg.loss_th.aux != SOFL_LOSS_OFF &&
    analog_in.aux < state_reg.loss_th.aux |=> flags.aux_input_loss_flag)
    else $error("aux loss flag missing");
  a_subst_val: assert property (
    @(posedge pclk) disable iff (!presetn)
    flags.aux_input_loss_flag |->
    analog_used.aux == $past(state_reg.loss_th.aux))
    else $error("threshold not substituted");
  a_decel_loss: assert property (
    @(posedge pclk) disable iff (!presetn)
    flags.aux_input_loss_flag |-> decel_stop_req)
    else $error("no stop request on loss");
  a_relay_boost: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg.sel == SOFL_OPT_BOOST
    |=> relay_output_terminal == $past(flags.second_stage_boost))
    else $error("boost not routed to relay");
  a_ascii_ignore: assert property (
    @(posedge pclk) disable iff (!presetn)
    ascii_frame_ok && !rtu_frame_ok && flags.link_silence_flag
    |=> flags.link_silence_flag)
    else $error("ascii frame cleared silence flag");
  a_silence_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    flags.link_silence_flag && !frame_seen
    |=> flags.link_silence_flag)
    else $error("silence flag dropped without traffic");
  a_timeout_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(flags.link_silence_flag) |-> timeout_event)
    else $error("no timeout event with silence");
  a_frame_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rtu_frame_ok |=> !flags.link_silence_flag ##0
    state_reg.silent_ticks == 16'h0000)
    else $error("frame did not restart timer");

  c_boost_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    flags.second_stage_boost ##[1:50] !flags.second_stage_boost);
  c_silence: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(flags.link_silence_flag));
  c_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));
  c_relay: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(relay_output_terminal));

endmodule : sofl_top

// ### sim/sofl_partner.sv
// far side model: motor encoder and modbus master frame strobes
`timescale 1ns/1ps
module sofl_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic spin,
  input wire logic [7:0] rtu_gap,
  input wire logic [7:0] ascii_gap,
  output logic encoder_pulse,
  output logic rtu_frame_ok,
  output logic ascii_frame_ok
);
  logic [7:0] rtu_cnt;
  logic [7:0] asc_cnt;

  // ***********************************************************
  // pulse generators
  // ***********************************************************
  // a gap of zero keeps the master quiet so the silence timer can run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_pulse <= 1'b0;
      rtu_cnt <= 8'h00;
      asc_cnt <= 8'h00;
      rtu_frame_ok <= 1'b0;
      ascii_frame_ok <= 1'b0;
    end else begin
      if (spin) begin
        encoder_pulse <= ~encoder_pulse; // motor turning, edges each cycle
      end
      rtu_cnt <= (rtu_cnt >= rtu_gap) ? 8'h00 : rtu_cnt + 8'h01;
      asc_cnt <= (asc_cnt >= ascii_gap) ? 8'h00 : asc_cnt + 8'h01;
      rtu_frame_ok <= (rtu_gap != 8'h00) && (rtu_cnt == rtu_gap);
      ascii_frame_ok <= (ascii_gap != 8'h00) && (asc_cnt == ascii_gap);
    end
  end
endmodule : sofl_partner

// ### sim/tb_sofl_top.sv
// self-checking bench for the status output flag block
`timescale 1ns/1ps
module tb_sofl_top;
  import sofl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, card_fitted = 0, encoder_pulse, spin = 0;
  logic [15:0] velocity_error = 16'h0, load_position = 16'h0;
  logic [15:0] target_position = 16'h1;
  sofl_analog_t analog_in = '0, analog_used;
  logic [7:0] process_variable = 8'h00, rtu_gap = 8'h00, ascii_gap = 8'h00;
  logic forward_run_command = 0, rtu_frame_ok, ascii_frame_ok;
  logic relay_output_terminal, decel_stop_req, timeout_event, irq;
  logic [1:0] timeout_action_select;
  sofl_flags_t flags;
  int num_errors = 0, comparisons = 0, ev_cnt = 0, i;
  logic [7:0] codes [9] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c, 8'h1d,
                            8'h1f, 8'h20, 8'h00};
  logic [8:0] rexp = 9'b110101000;

  // ***********************************************************
  // clock, instances
  // ***********************************************************
  always #5 pclk = ~pclk;
  // timer shortened to 2 cycles a tick to keep the run brief
  sofl_top #(.TICK_CYC(2), .ZS_W(16)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_fitted(card_fitted), .encoder_pulse(encoder_pulse),
    .velocity_error(velocity_error), .load_position(load_position),
    .target_position(target_position), .analog_in(analog_in),
    .process_variable(process_variable),
    .forward_run_command(forward_run_command), .rtu_frame_ok(rtu_frame_ok),
    .ascii_frame_ok(ascii_frame_ok),
    .relay_output_terminal(relay_output_terminal), .flags(flags),
    .analog_used(analog_used), .decel_stop_req(decel_stop_req),
    .timeout_event(timeout_event),
    .timeout_action_select(timeout_action_select), .irq(irq));
  sofl_partner far_side (.pclk(pclk), .presetn(presetn), .spin(spin),
    .rtu_gap(rtu_gap), .ascii_gap(ascii_gap), .encoder_pulse(encoder_pulse),
    .rtu_frame_ok(rtu_frame_ok), .ascii_frame_ok(ascii_frame_ok));
  // count silence events, one pulse expected per timeout
  always @(negedge pclk) begin
    if (timeout_event === 1'b1) ev_cnt++;
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task chk1(input logic s, input logic x);
    check({31'h0, s}, {31'h0, x});
  endtask : chk1
  // one apb transfer; answer taken at the edge where pready is high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20) begin
      num_errors++;
      report_and_stop();
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q, x);
  endtask : rd
  // sync stages plus flag register: results sampled mid-cycle
  task wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(SOFL_OFF_SEL, 32'h0);
    rd(SOFL_OFF_LOSSTH, 32'h00ffffff);
    rd(SOFL_OFF_PVLIM, 32'h00006400);
    rd(SOFL_OFF_TIMEOUT, 32'h0);
    rd(8'h30, 32'h0);
    chk1(e, 1'b1);
    // encoder flags, card absent then fitted
    wr(SOFL_OFF_SPDERR, {16'd10, 16'd100});
    @(posedge pclk);
    velocity_error <= 16'd101;
    wt(20);
    chk1(flags.zero_speed_flag, 1'b0);
    chk1(flags.speed_error_flag, 1'b0);
    @(posedge pclk);
    card_fitted <= 1;
    wt(20);
    chk1(flags.zero_speed_flag, 1'b1);
    chk1(flags.speed_error_flag, 1'b1);
    @(posedge pclk);
    spin <= 1;
    velocity_error <= 16'd100;
    target_position <= 16'h0;
    wt(8);
    chk1(flags.zero_speed_flag, 1'b0);
    chk1(flags.speed_error_flag, 1'b0);
    chk1(flags.position_done_flag, 1'b1);
    @(posedge pclk);
    spin <= 0;
    velocity_error <= 16'd200;
    target_position <= 16'h5;
    // analog loss: voltage below, current at threshold, aux below
    analog_in <= '{voltage: 8'd10, current: 8'd50, aux: 8'd0};
    wr(SOFL_OFF_LOSSTH, 32'h003c3228);
    wt(20);
    check({8'h0, analog_used}, 32'h003c3228);
    check({29'h0, flags.voltage_loss_flag, flags.current_input_loss_flag,
           flags.aux_input_loss_flag}, 32'h5);
    chk1(decel_stop_req, 1'b1);
    // each option code routes its own flag to the relay
    for (i = 0; i < 9; i++) begin
      wr(SOFL_OFF_SEL, {24'h0, codes[i]});
      wt(4);
      chk1(relay_output_terminal, rexp[8-i]);
    end
    wr(SOFL_OFF_LOSSTH, 32'h00ff3228);
    wt(4);
    chk1(flags.voltage_loss_flag, 1'b0);
    check({24'h0, analog_used.voltage}, 32'ha);
    // boost hysteresis with interrupt on its rise
    wr(SOFL_OFF_PVLIM, 32'h0000461e);
    wr(SOFL_OFF_IMASK, 32'h2);
    apb(1'b0, SOFL_OFF_ISTAT, 32'h0);
    @(posedge pclk);
    forward_run_command <= 1;
    process_variable <= 8'd20;
    wt(6);
    chk1(flags.second_stage_boost, 1'b1);
    chk1(irq, 1'b1);
    rd(SOFL_OFF_ISTAT, 32'h2);
    wt(2);
    chk1(irq, 1'b0);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      process_variable <= (i == 1) ? 8'd80 : (i == 3) ? 8'd20 : 8'd50;
      wt(4);
      chk1(flags.second_stage_boost, i != 1 && i != 2);
    end
    @(posedge pclk);
    forward_run_command <= 0;
    wt(6);
    chk1(flags.second_stage_boost, 1'b0);
    // link silence on rtu traffic only
    @(posedge pclk);
    rtu_gap <= 8'd4;
    wr(SOFL_OFF_CTRL, 32'h20);
    wr(SOFL_OFF_TIMEOUT, 32'h3);
    wt(40);
    chk1(flags.link_silence_flag, 1'b0);
    check({30'h0, timeout_action_select}, 32'h2);
    @(posedge pclk);
    rtu_gap <= 8'd0;
    ascii_gap <= 8'd3;
    wt(30);
    chk1(flags.link_silence_flag, 1'b1);
    check(ev_cnt, 32'h1);
    @(posedge pclk);
    rtu_gap <= 8'd4;
    wt(12);
    chk1(flags.link_silence_flag, 1'b0);
    report_and_stop();
  end
  // hang guard
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb_sofl_top
